// ===== flash_port_map.vh
// constants for the serial flash boot port
// Summary of operation
// RL1: the flash pause and write-protect inputs are never driven; board pulls them high.
// RL2: writes requested by the control host use page-program operations.
// RL3: no page or sector size is imposed; users plan around the flash's erase size.
// RL4: while reset is low, clock, data out and select 0 outputs float.
// RL5: select 1 stays driven during reset.
// RL6: an external programmer drives the flash only while the device is held in reset.
// RL7: master, clock mode 0, fixed serial clock near 33.3 MHz, two selects.
// RL8: reads use fast read 0x0B with three address bytes and one dummy byte.
// RL9: boot reads header bytes 0x0000 to 0x0007 on select 0, then loads routine.
// RL10: flash auto-increments its address so reads stream after one address phase.
// RL11: selects never low together; active select returns high between transactions.
`ifndef FLASH_PORT_MAP_VH
`define FLASH_PORT_MAP_VH
`define CMD_FAST_READ 8'h0B
`define CMD_PAGE_PROG 8'h02
`define CMD_WRITE_EN 8'h06
`define CMD_READ_STATUS 8'h05
`define STATUS_BUSY_BIT 0
`define BOOT_HDR_ADDR 24'h000000
`define IDX_ADDR_HI 4'h1
`define IDX_ADDR_MID 4'h2
`define IDX_ADDR_LO 4'h3
`define IDX_PROG_DATA 4'h4
`define IDX_READ_DATA 4'h5
`define IDX_POLL_DATA 4'h1
`define IDX_HDR_LAST 4'hC
`define IDX_MAX 4'hF
`define BIT_LAST 3'h7
`define SYS_FREQ_KHZ 250000
`define SCLK_FREQ_KHZ 33300
`define SYS_PERIOD_NS 4
`define CS_HIGH_NS 300
`define HALF_CYCLES ((`SYS_FREQ_KHZ + 2 * `SCLK_FREQ_KHZ - 1) / (2 * `SCLK_FREQ_KHZ))
`define GAP_CYCLES ((`CS_HIGH_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define PROG_ADDR_W 16
`endif

// ===== flash_input_sync.v
// two-stage synchroniser for the flash data input
`timescale 1ns/1ps
module flash_input_sync
(
   input wire clk_in,
   input wire rst_b_in,
   input wire d_in,
   output wire q_out
);
   reg meta_r;
   reg sync_r;

   always @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end
      else
      begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;
endmodule

// ===== serial_flash_boot_port.v
// serial flash port: boot loader and page-program sequencer
`timescale 1ns/1ps
`include "flash_port_map.vh"
module serial_flash_boot_port
(
   input wire CLK_SYS_IN,
   input wire RST_B_IN,
   input wire FLASH_SERIAL_DATA_IN,
   input wire WR_REQ_IN,
   input wire WR_SEL_IN,
   input wire [23:0] WR_ADDR_IN,
   input wire [7:0] WR_DATA_IN,
   input wire WR_DATA_VALID_IN,
   input wire WR_LAST_IN,
   output reg FLASH_SERIAL_CLOCK_OUT,
   output reg FLASH_SERIAL_CLOCK_OE_OUT,
   output reg FLASH_SERIAL_DATA_OUT,
   output reg FLASH_SERIAL_DATA_OE_OUT,
   output reg FLASH_SELECT0_N_OUT,
   output reg FLASH_SELECT0_OE_OUT,
   output reg FLASH_SELECT1_N_OUT,
   output reg PROG_WE_OUT,
   output reg [`PROG_ADDR_W-1:0] PROG_ADDR_OUT,
   output reg [7:0] PROG_DATA_OUT,
   output reg BOOT_DONE_OUT,
   output reg WR_BUSY_OUT,
   output reg WR_DATA_TAKE_OUT
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_GAP = 2'h1;
   localparam [1:0] ST_SHIFT = 2'h2;
   localparam [1:0] ST_HOLD = 2'h3;

   localparam [2:0] J_HDR = 3'h0;
   localparam [2:0] J_LOAD = 3'h1;
   localparam [2:0] J_IDLE = 3'h2;
   localparam [2:0] J_WREN = 3'h3;
   localparam [2:0] J_PROG = 3'h4;
   localparam [2:0] J_POLL = 3'h5;

   localparam integer HALF_INT = `HALF_CYCLES - 1;
   localparam integer GAP_INT = `GAP_CYCLES - 1;
   localparam [7:0] HALF_LAST = HALF_INT[7:0];
   localparam [7:0] GAP_LAST = GAP_INT[7:0];

   wire miso_s;
   reg [1:0] st_r;
   reg [2:0] job_r;
   reg [7:0] cnt_r;
   reg [2:0] bit_r;
   reg [3:0] idx_r;
   reg [7:0] tx_r;
   reg [7:0] rx_r;
   reg [23:0] addr_r;
   reg [23:0] remain_r;
   reg [55:0] hdr_r;
   reg sel1_r;
   reg last_r;
   reg [7:0] rxb;
   reg [63:0] hdr_full;
   reg [3:0] idx_nxt;
   reg [7:0] first_byte;
   reg [7:0] next_byte;
   reg [`PROG_ADDR_W-1:0] load_addr_r;

   // opcode and address byte for a given byte slot of a transaction
   function [7:0] tx_byte;
      input [2:0] job;
      input [3:0] idx;
      input [23:0] addr;
      begin
         tx_byte = 8'h00;
         if (idx == 4'h0)
         begin
            case (job)
               J_WREN: tx_byte = `CMD_WRITE_EN;
               J_PROG: tx_byte = `CMD_PAGE_PROG; // RL2
               J_POLL: tx_byte = `CMD_READ_STATUS;
               default: tx_byte = `CMD_FAST_READ; // RL8
            endcase
         end
         else if (idx == `IDX_ADDR_HI && job != J_WREN && job != J_POLL)
            tx_byte = addr[23:16];
         else if (idx == `IDX_ADDR_MID && job != J_WREN && job != J_POLL)
            tx_byte = addr[15:8];
         else if (idx == `IDX_ADDR_LO && job != J_WREN && job != J_POLL)
            tx_byte = addr[7:0];
      end
   endfunction

   flash_input_sync u_miso_sync
   (
      .clk_in(CLK_SYS_IN),
      .rst_b_in(RST_B_IN),
      .d_in(FLASH_SERIAL_DATA_IN),
      .q_out(miso_s)
   );

   always @*
   begin
      rxb = {rx_r[6:0], miso_s};
      hdr_full = {hdr_r, rxb};
      // slot count saturates so a long stream never wraps back to the opcode slot
      idx_nxt = (idx_r == `IDX_MAX) ? idx_r : idx_r + 4'h1;
      first_byte = tx_byte(job_r, 4'h0, addr_r);
      next_byte = tx_byte(job_r, idx_nxt, addr_r);
   end

   // no pause or write-protect pins exist on this port RL1
   // oe registers reset low so the pins float while reset is held RL4 RL6
   always @(posedge CLK_SYS_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         FLASH_SERIAL_CLOCK_OUT <= 1'b0;
         FLASH_SERIAL_CLOCK_OE_OUT <= 1'b0; // RL4
         FLASH_SERIAL_DATA_OUT <= 1'b0;
         FLASH_SERIAL_DATA_OE_OUT <= 1'b0; // RL4
         FLASH_SELECT0_N_OUT <= 1'b1;
         FLASH_SELECT0_OE_OUT <= 1'b0; // RL4
         FLASH_SELECT1_N_OUT <= 1'b1; // RL5
         PROG_WE_OUT <= 1'b0;
         PROG_ADDR_OUT <= {`PROG_ADDR_W{1'b0}};
         PROG_DATA_OUT <= 8'h00;
         BOOT_DONE_OUT <= 1'b0;
         WR_BUSY_OUT <= 1'b0;
         WR_DATA_TAKE_OUT <= 1'b0;
         st_r <= ST_GAP;
         job_r <= J_HDR;
         cnt_r <= 8'h00;
         bit_r <= 3'h0;
         idx_r <= 4'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         addr_r <= `BOOT_HDR_ADDR; // RL9
         remain_r <= 24'h000000;
         hdr_r <= 56'h0;
         sel1_r <= 1'b0;
         last_r <= 1'b0;
         load_addr_r <= {`PROG_ADDR_W{1'b0}};
      end
      else
      begin
         FLASH_SERIAL_CLOCK_OE_OUT <= 1'b1;
         FLASH_SERIAL_DATA_OE_OUT <= 1'b1;
         FLASH_SELECT0_OE_OUT <= 1'b1;
         PROG_WE_OUT <= 1'b0;
         WR_DATA_TAKE_OUT <= 1'b0;
         case (st_r)
            ST_IDLE:
            begin
               if (WR_REQ_IN)
               begin
                  addr_r <= WR_ADDR_IN;
                  sel1_r <= WR_SEL_IN;
                  WR_BUSY_OUT <= 1'b1;
                  job_r <= J_WREN;
                  st_r <= ST_GAP;
                  cnt_r <= 8'h00;
               end
            end
            ST_GAP:
            begin
               if (job_r == J_IDLE && WR_REQ_IN)
               begin
                  addr_r <= WR_ADDR_IN;
                  sel1_r <= WR_SEL_IN;
                  WR_BUSY_OUT <= 1'b1;
                  job_r <= J_WREN;
               end
               // selects stay high for the flash's minimum deselect time RL11
               if (cnt_r != GAP_LAST)
                  cnt_r <= cnt_r + 8'h01;
               else if (job_r == J_IDLE)
                  st_r <= WR_REQ_IN ? ST_GAP : ST_IDLE;
               else
               begin
                  FLASH_SELECT0_N_OUT <= sel1_r; // RL11
                  FLASH_SELECT1_N_OUT <= ~sel1_r; // RL7
                  tx_r <= first_byte;
                  FLASH_SERIAL_DATA_OUT <= first_byte[7];
                  idx_r <= 4'h0;
                  bit_r <= 3'h0;
                  cnt_r <= 8'h00;
                  st_r <= ST_SHIFT;
               end
            end
            ST_HOLD:
            begin
               // clock parks low while the host has no byte ready
               if (WR_DATA_VALID_IN)
               begin
                  tx_r <= WR_DATA_IN;
                  FLASH_SERIAL_DATA_OUT <= WR_DATA_IN[7];
                  last_r <= WR_LAST_IN;
                  WR_DATA_TAKE_OUT <= 1'b1;
                  cnt_r <= 8'h00;
                  st_r <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (cnt_r != HALF_LAST)
                  cnt_r <= cnt_r + 8'h01;
               else
               begin
                  cnt_r <= 8'h00;
                  // mode 0: rise while data stable, sample and shift at fall RL7
                  if (!FLASH_SERIAL_CLOCK_OUT)
                     FLASH_SERIAL_CLOCK_OUT <= 1'b1; // RL7
                  else
                  begin
                     FLASH_SERIAL_CLOCK_OUT <= 1'b0;
                     rx_r <= rxb;
                     bit_r <= bit_r + 3'h1;
                     if (bit_r != `BIT_LAST)
                     begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        FLASH_SERIAL_DATA_OUT <= tx_r[6];
                     end
                     else
                     begin
                        idx_r <= idx_nxt;
                        if ((job_r == J_HDR && idx_r == `IDX_HDR_LAST)
                           || (job_r == J_LOAD && idx_r >= `IDX_READ_DATA
                              && remain_r == 24'h000001)
                           || job_r == J_WREN
                           || (job_r == J_PROG && idx_r >= `IDX_PROG_DATA && last_r)
                           || (job_r == J_POLL && idx_r >= `IDX_POLL_DATA
                              && !rxb[`STATUS_BUSY_BIT]))
                        begin
                           FLASH_SELECT0_N_OUT <= 1'b1; // RL11
                           FLASH_SELECT1_N_OUT <= 1'b1; // RL11
                           st_r <= ST_GAP;
                           case (job_r)
                              J_HDR:
                              begin
                                 remain_r <= hdr_full[63:40];
                                 addr_r <= hdr_full[31:8]; // RL9
                                 if (hdr_full[63:40] == 24'h000000)
                                 begin
                                    job_r <= J_IDLE;
                                    BOOT_DONE_OUT <= 1'b1;
                                 end
                                 else
                                    job_r <= J_LOAD;
                              end
                              J_LOAD:
                              begin
                                 job_r <= J_IDLE;
                                 BOOT_DONE_OUT <= 1'b1;
                              end
                              J_WREN: job_r <= J_PROG;
                              J_PROG: job_r <= J_POLL;
                              default:
                              begin
                                 job_r <= J_IDLE;
                                 WR_BUSY_OUT <= 1'b0;
                              end
                           endcase
                        end
                        else if (job_r == J_PROG && idx_nxt >= `IDX_PROG_DATA)
                        begin
                           if (WR_DATA_VALID_IN)
                           begin
                              tx_r <= WR_DATA_IN;
                              FLASH_SERIAL_DATA_OUT <= WR_DATA_IN[7];
                              last_r <= WR_LAST_IN;
                              WR_DATA_TAKE_OUT <= 1'b1;
                           end
                           else
                              st_r <= ST_HOLD;
                        end
                        else
                        begin
                           tx_r <= next_byte;
                           FLASH_SERIAL_DATA_OUT <= next_byte[7];
                        end
                        // data phase of a read streams on one address phase RL10
                        if (job_r == J_HDR && idx_r >= `IDX_READ_DATA)
                           hdr_r <= hdr_full[55:0]; // RL9
                        if (job_r == J_LOAD && idx_r >= `IDX_READ_DATA)
                        begin
                           PROG_WE_OUT <= 1'b1; // RL9
                           PROG_DATA_OUT <= rxb;
                           PROG_ADDR_OUT <= load_addr_r;
                           load_addr_r <= load_addr_r + 1'b1;
                           remain_r <= remain_r - 24'h000001;
                        end
                        if (job_r == J_PROG && idx_r == 4'h0)
                           last_r <= 1'b0;
                     end
                  end
               end
            end
            default: st_r <= ST_GAP;
         endcase
      end
   end
endmodule

// ===== serial_flash_boot_port_asserts.sv
// assertions on the serial flash boot port pins
`timescale 1ns/1ps
module serial_flash_boot_port_asserts
(
   input wire CLK_SYS_IN,
   input wire RST_B_IN,
   input wire WR_REQ_IN,
   input wire FLASH_SERIAL_CLOCK_OUT,
   input wire FLASH_SERIAL_CLOCK_OE_OUT,
   input wire FLASH_SERIAL_DATA_OUT,
   input wire FLASH_SERIAL_DATA_OE_OUT,
   input wire FLASH_SELECT0_N_OUT,
   input wire FLASH_SELECT0_OE_OUT,
   input wire FLASH_SELECT1_N_OUT,
   input wire PROG_WE_OUT,
   input wire BOOT_DONE_OUT,
   input wire WR_BUSY_OUT
);
   reg [7:0] gap_r;
   wire idle = FLASH_SELECT0_N_OUT && FLASH_SELECT1_N_OUT;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   // saturates so that long idle spells stay legal
   always @(posedge CLK_SYS_IN or negedge RST_B_IN)
      if (!RST_B_IN)
         gap_r <= 8'h00;
      else if (!idle)
         gap_r <= 8'h00;
      else if (gap_r != 8'hFF)
         gap_r <= gap_r + 8'h01;
   sequence high_phase;
      FLASH_SERIAL_CLOCK_OUT [*4] ##1 !FLASH_SERIAL_CLOCK_OUT;
   endsequence
   sequence select_fall;
      $fell(FLASH_SELECT0_N_OUT) || $fell(FLASH_SELECT1_N_OUT);
   endsequence
   a_reset_float: assert property (disable iff (1'b0)
      !RST_B_IN |-> !FLASH_SERIAL_CLOCK_OE_OUT && !FLASH_SERIAL_DATA_OE_OUT
      && !FLASH_SELECT0_OE_OUT) else $error("pins driven in reset");
   a_select1_held: assert property (disable iff (1'b0)
      !RST_B_IN |-> FLASH_SELECT1_N_OUT) else $error("select1 low in reset");
   a_selects_apart: assert property (
      !(!FLASH_SELECT0_N_OUT && !FLASH_SELECT1_N_OUT)) else $error("both selects low");
   // 75 cycles of 4 ns give the 300 ns deselect time
   a_deselect_gap: assert property (
      select_fall |-> gap_r >= 8'h4B) else $error("deselect gap short");
   a_clock_idle: assert property (
      idle |-> !FLASH_SERIAL_CLOCK_OUT) else $error("clock not low while idle");
   a_half_period: assert property (
      $rose(FLASH_SERIAL_CLOCK_OUT) |-> high_phase) else $error("high phase length");
   a_mosi_stable: assert property (
      FLASH_SERIAL_CLOCK_OUT && $past(FLASH_SERIAL_CLOCK_OUT) |-> $stable(FLASH_SERIAL_DATA_OUT))
      else $error("data moved in high phase");
   a_cmd_msb: assert property (
      select_fall |-> !FLASH_SERIAL_DATA_OUT) else $error("command top bit set");
   a_boot_sel0: assert property (
      !BOOT_DONE_OUT |-> FLASH_SELECT1_N_OUT) else $error("select1 used in boot");
   a_prog_spacing: assert property (
      PROG_WE_OUT |=> !PROG_WE_OUT [*8]) else $error("program writes too close");
   a_write_accept: assert property (
      WR_REQ_IN && BOOT_DONE_OUT && !WR_BUSY_OUT |=> WR_BUSY_OUT) else $error("request lost");
endmodule
bind serial_flash_boot_port serial_flash_boot_port_asserts chk (.CLK_SYS_IN, .RST_B_IN,
   .WR_REQ_IN, .FLASH_SERIAL_CLOCK_OUT, .FLASH_SERIAL_CLOCK_OE_OUT, .FLASH_SERIAL_DATA_OUT,
   .FLASH_SERIAL_DATA_OE_OUT, .FLASH_SELECT0_N_OUT, .FLASH_SELECT0_OE_OUT,
   .FLASH_SELECT1_N_OUT, .PROG_WE_OUT, .BOOT_DONE_OUT, .WR_BUSY_OUT);

// ===== flash_partner_model.sv
// behavioural serial flash answering on both selects
`timescale 1ns/1ps
module flash_partner_model
(
   input wire sclk_in,
   input wire mosi_in,
   input wire sel0_n_in,
   input wire sel1_n_in,
   output reg miso_out = 1'b0
);
   reg [7:0] mem [0:511];
   reg [7:0] wbuf [0:7];
   reg [7:0] sh, cmd, od;
   reg [23:0] addr;
   reg [25:0] pinfo;
   reg wren = 1'b0;
   integer bits = 0, nb = 0, nw = 0, polls = 3;
   wire sel = !sel0_n_in || !sel1_n_in;
   always @(sel)
   begin
      bits = 0;
      nb = 0;
      if (!sel)
         miso_out = ~miso_out; // released line never keeps its last level
   end
   always @(posedge sclk_in)
      if (sel)
      begin
         sh = {sh[6:0], mosi_in};
         bits = bits + 1;
         if (bits % 8 == 0)
         begin
            if (nb == 0) cmd = sh;
            if (nb == 0 && sh == 8'h06) wren = 1'b1;
            if (nb >= 1 && nb <= 3 && cmd != 8'h05) addr = {addr[15:0], sh};
            if (cmd == 8'h02 && nb == 3) pinfo = {wren, !sel1_n_in, addr};
            if (cmd == 8'h02 && nb >= 4 && nw < 8) wbuf[nw] = sh;
            if (cmd == 8'h02 && nb >= 4) nw = nw + 1;
            nb = nb + 1;
         end
      end
   // three busy answers before ready make the program step a slow one
   always @(negedge sclk_in)
      if (sel)
      begin
         if (bits % 8 == 0)
            od = cmd == 8'h05 ? {7'h00, polls > 0} : cmd == 8'h0B && nb >= 5 ?
               mem[(addr + nb - 5) & 511] : 8'h5A;
         if (bits % 8 == 0 && cmd == 8'h05 && polls > 0) polls = polls - 1;
         miso_out = od[7 - bits % 8];
      end
endmodule

// ===== test_serial_flash_boot_port.sv
// self-checking bench for the serial flash boot port
`timescale 1ns/1ps
module test_serial_flash_boot_port;
   // first clock edge is a fall, so reset lands before any rising edge
   reg clk = 1'b1, rst_b = 1'b1, wr_req = 1'b0, wr_sel = 1'b0;
   reg wr_valid = 1'b0, wr_last = 1'b0;
   reg [23:0] wr_addr = 24'h000000;
   reg [7:0] wr_data = 8'h00;
   reg [7:0] b [0:1];
   wire sclk, sclk_oe, mosi, mosi_oe, sel0, sel0_oe, sel1, miso, we, done, busy, take;
   wire [15:0] pa;
   wire [7:0] pd;
   reg [23:0] expq [$];
   integer failures = 0, num_checks = 0, cyc = 0, i, n;
   serial_flash_boot_port dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
      .FLASH_SERIAL_DATA_IN(miso), .WR_REQ_IN(wr_req), .WR_SEL_IN(wr_sel),
      .WR_ADDR_IN(wr_addr), .WR_DATA_IN(wr_data), .WR_DATA_VALID_IN(wr_valid),
      .WR_LAST_IN(wr_last), .FLASH_SERIAL_CLOCK_OUT(sclk), .FLASH_SERIAL_CLOCK_OE_OUT(sclk_oe),
      .FLASH_SERIAL_DATA_OUT(mosi), .FLASH_SERIAL_DATA_OE_OUT(mosi_oe),
      .FLASH_SELECT0_N_OUT(sel0), .FLASH_SELECT0_OE_OUT(sel0_oe), .FLASH_SELECT1_N_OUT(sel1),
      .PROG_WE_OUT(we), .PROG_ADDR_OUT(pa), .PROG_DATA_OUT(pd), .BOOT_DONE_OUT(done),
      .WR_BUSY_OUT(busy), .WR_DATA_TAKE_OUT(take));
   // select 0 has a board pull-up, so a floating select deselects the flash
   flash_partner_model flash (.sclk_in(sclk_oe ? sclk : 1'b0), .mosi_in(mosi_oe ? mosi : ~sclk),
      .sel0_n_in(sel0_oe ? sel0 : 1'b1), .sel1_n_in(sel1), .miso_out(miso));
   always #2 clk = ~clk;
   task check(input [31:0] exp, input [31:0] got, input string what);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wait_for(input integer which, input bit level, input integer lim);
      integer c;
      c = 0;
      while (((which == 0) ? done : (which == 1) ? busy : take) !== level && c < lim)
      begin
         @(negedge clk);
         c = c + 1;
      end
   endtask
   task do_reset;
      rst_b = 1'b0;
      repeat (12) @(negedge clk);
      check(0, {sclk_oe, mosi_oe, sel0_oe}, "pin enables");
      check(1, sel1, "select1");
      rst_b = 1'b1;
      $display("reset test done");
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         end_sim;
      end
   end
   always @(negedge clk)
      if (we === 1'b1)
      begin
         n = expq.size();
         if (n == 0) check(0, 1, "extra load");
         else check(expq.pop_front(), {pa, pd}, "program load");
      end
   initial
   begin
      i = $urandom(21850);
      for (i = 0; i < 8; i = i + 1) flash.mem[i] = (i == 2) ? 8'h03 : (i == 5) ? 8'h01 : 8'h00;
      for (i = 0; i < 3; i = i + 1) flash.mem[256 + i] = $urandom;
      @(negedge clk);
      do_reset;
      wr_req = 1'b1;
      @(negedge clk);
      wr_req = 1'b0;
      check(0, busy, "busy during boot");
      repeat (300) @(negedge clk);
      do_reset;
      for (i = 0; i < 3; i = i + 1) expq.push_back({i[15:0], flash.mem[256 + i]});
      wait_for(0, 1'b1, 6000);
      // let the load watcher take the final byte before the queue is counted
      @(negedge clk);
      check(1, done, "boot done");
      check(7, {sclk_oe, mosi_oe, sel0_oe}, "pin enables after reset");
      check(0, expq.size(), "loads left");
      $display("boot test done");
      wr_sel = 1'b1;
      wr_addr = 24'h000040;
      wr_req = 1'b1;
      @(negedge clk);
      wr_req = 1'b0;
      check(1, busy, "busy");
      for (i = 0; i < 2; i = i + 1)
      begin
         wr_valid = 1'b0;
         repeat (20 + $urandom % 40) @(negedge clk);
         b[i] = $urandom;
         wr_data = b[i];
         wr_last = (i == 1);
         wr_valid = 1'b1;
         wait_for(2, 1'b1, 3000);
         check(1, take, "byte taken");
      end
      wr_valid = 1'b0;
      wait_for(1, 1'b0, 4000);
      check(0, busy, "busy end");
      check({2'b11, 24'h000040}, flash.pinfo, "program setup");
      check({b[0], b[1]}, {flash.wbuf[0], flash.wbuf[1]}, "page data");
      check(2, flash.nw, "byte count");
      check(0, flash.polls, "status polls");
      $display("write test done");
      end_sim;
   end
endmodule
